// ==== design/capture_pkg.sv ====
// Constants and helpers shared by the capture unit and its event detector.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package capture_pkg;

  // Register byte offsets (low address byte only is decoded)
  localparam logic [7:0] addr_control = 8'h00;
  localparam logic [7:0] addr_capture_low = 8'h04;
  localparam logic [7:0] addr_capture_high = 8'h08;
  localparam logic [7:0] addr_irq_flag = 8'h0c;
  localparam logic [7:0] addr_irq_enable = 8'h10;
  localparam logic [7:0] addr_shutdown = 8'h14;
  localparam logic [7:0] addr_timer_config = 8'h18;
  localparam logic [7:0] addr_timer_low = 8'h1c;
  localparam logic [7:0] addr_timer_high = 8'h20;
  localparam logic [7:0] addr_pin_control = 8'h24;
  localparam logic [7:0] addr_alt_select = 8'h28;

  // Reset values
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] shutdown_reset = 8'h00;

  // Field positions
  localparam int flag_bit = 0;
  localparam int enable_bit = 0;
  localparam int timer_run_bit = 0;
  localparam int timer_ext_bit = 1;
  localparam int pin_dir_bit = 0;
  localparam int pin_latch_bit = 1;
  localparam int alt_bit = 0;

  // Capture mode select codes
  localparam logic [3:0] mode_off = 4'h0;
  localparam logic [3:0] mode_fall = 4'h4;
  localparam logic [3:0] mode_rise = 4'h5;
  localparam logic [3:0] mode_rise4 = 4'h6;
  localparam logic [3:0] mode_rise16 = 4'h7;

  // Prescaler wrap points
  localparam logic [3:0] presc_max1 = 4'h0;
  localparam logic [3:0] presc_max4 = 4'h3;
  localparam logic [3:0] presc_max16 = 4'hf;

  // Instruction clock is the bus clock divided by four
  localparam logic [1:0] instr_div_max = 2'h3;

  // AHB encodings
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic hresp_okay = 1'h0;

  // True for the four capture modes
  function automatic logic is_capture_mode(input logic [3:0] mode);
    is_capture_mode = (mode == mode_fall) || (mode == mode_rise) ||
                      (mode == mode_rise4) || (mode == mode_rise16);
  endfunction : is_capture_mode

endpackage : capture_pkg

// ==== design/capture_if.sv ====
// Signals between the capture unit and its edge/prescaler detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface capture_if;
  logic [3:0] mode;
  logic level;
  logic event_pulse;
  logic [3:0] presc_count;
  modport detector(input mode, input level, output event_pulse, output presc_count);
  modport unit(output mode, output level, input event_pulse, input presc_count);
endinterface : capture_if

// ==== design/capture_event_detector.sv ====
// Edge detector and event prescaler of the capture unit.
// Assumes level is already synchronised to clk.
`timescale 1ns/1ps
module capture_event_detector (
  input wire logic clk,                 // Bus clock
  input wire logic arst_n,              // Asynchronous reset, active low
  capture_if.detector cif               // Mode, level and event
);

  logic prev_level;
  logic rise;
  logic fall;
  logic capturing;
  logic [3:0] presc_max;

  // Previous pin level for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= cif.level;
    end
  end

  // Edges and wrap point of the selected prescale
  always_comb begin
    rise = cif.level & ~prev_level;
    fall = ~cif.level & prev_level;
    capturing = capture_pkg::is_capture_mode(cif.mode);
    case (cif.mode)
      capture_pkg::mode_rise4: presc_max = capture_pkg::presc_max4;
      capture_pkg::mode_rise16: presc_max = capture_pkg::presc_max16;
      default: presc_max = capture_pkg::presc_max1;
    endcase
  end

  // Prescaler counter, cleared when off or not capturing, kept across prescale changes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cif.presc_count <= 4'h0;
    end else if (!capturing) begin
      cif.presc_count <= 4'h0;
    end else if (rise && cif.mode != capture_pkg::mode_fall) begin
      if (cif.presc_count >= presc_max) begin
        cif.presc_count <= 4'h0;
      end else begin
        cif.presc_count <= cif.presc_count + 4'h1;
      end
    end
  end

  // Qualifying event
  assign cif.event_pulse = capturing &&
    ((cif.mode == capture_pkg::mode_fall && fall) ||
     (cif.mode != capture_pkg::mode_fall && rise && cif.presc_count >= presc_max));

  property p_falling;
    @(posedge clk) disable iff (!arst_n)
      (cif.mode == capture_pkg::mode_fall && $past(cif.mode) == capture_pkg::mode_fall && $fell(cif.level))
      |-> cif.event_pulse;
  endproperty
  a_falling: assert property (p_falling) else $error("falling edge missed");

  property p_rising;
    @(posedge clk) disable iff (!arst_n)
      (cif.mode == capture_pkg::mode_rise && $rose(cif.level)) |-> cif.event_pulse;
  endproperty
  a_rising: assert property (p_rising) else $error("rising edge missed");

  // A count left above the wrap by a prescale switch may fire at once
  property p_every4;
    @(posedge clk) disable iff (!arst_n)
      (cif.mode == capture_pkg::mode_rise4 && cif.event_pulse && cif.presc_count <= capture_pkg::presc_max4)
      |-> cif.presc_count == capture_pkg::presc_max4;
  endproperty
  a_every4: assert property (p_every4) else $error("divide by four event at wrong count");

  property p_presc_clear;
    @(posedge clk) disable iff (!arst_n)
      !capture_pkg::is_capture_mode(cif.mode) |=> cif.presc_count == 4'h0;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

  property p_presc_kept;
    @(posedge clk) disable iff (!arst_n)
      (capture_pkg::is_capture_mode(cif.mode) && !rise) |=> $stable(cif.presc_count);
  endproperty
  a_presc_kept: assert property (p_presc_kept) else $error("prescaler changed without edge");

endmodule : capture_event_detector

// ==== design/ccp_capture_unit.sv ====
// Input-capture unit with its companion 16-bit timer and AHB-Lite registers.
// Assumes one AHB-Lite master, single word transfers, pins asynchronous to clk.
//
// Summary of operation
// - A qualifying pin event copies the 16-bit timer count into the capture value.
// - Mode select picks falling, rising, every 4th or every 16th rising edge.
// - Each capture sets the flag; only software clears it.
// - A later capture overwrites the stored value, unread or not.
// - Events come from the pin level even when the pin drives out.
// - Mode changes may raise a false flag; software clears it afterwards.
// - Prescaler clears when off, not capturing, or on reset.
// - Prescaler is kept between prescale settings; software clears control first.
// - In sleep an internally clocked timer holds; external clocking keeps capturing.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ccp_capture_unit (
  input wire logic clk,                   // 100 MHz bus clock
  input wire logic arst_n,                // Asynchronous reset, active low
  input wire logic hsel,                  // Slave select
  input wire logic [31:0] haddr,          // Byte address
  input wire logic [1:0] htrans,          // Transfer type
  input wire logic hwrite,                // Write when high
  input wire logic [2:0] hsize,           // Transfer size, word only
  input wire logic [31:0] hwdata,         // Write data
  input wire logic hready,                // Bus ready
  output logic hreadyout,                 // Slave ready, always high
  output logic hresp,                     // Response, always OKAY
  output logic [31:0] hrdata,             // Read data
  input wire logic capture_pin_in,        // Capture pin level, main location
  input wire logic capture_pin_alt_in,    // Capture pin level, alternate location
  input wire logic timer_ext_clk_in,      // External timer clock pin
  input wire logic sleep,                 // Device in sleep, same clock domain
  output logic capture_pin_out,           // Pin output value
  output logic capture_pin_oe             // Pin output enable, high drives
);

  capture_if cif ();

  logic [7:0] control;
  logic [7:0] shutdown;
  logic capture_irq_flag;
  logic capture_irq_enable;
  logic timer_run;
  logic timer_ext;
  logic [15:0] timer_count;
  logic [15:0] capture_value;
  logic pin_dir_input;
  logic pin_latch;
  logic alt_select;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic ext_prev;
  logic ext_rise;
  logic [1:0] div_count;
  logic instr_tick;
  logic timer_tick;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic wr_en;
  logic accept;
  logic flag_clear;
  logic [31:0] read_value;
  logic unused_bits;

  // Bus answers at once and never errors
  assign hreadyout = 1'b1;
  assign hresp = capture_pkg::hresp_okay;
  assign unused_bits = ^{hsize, haddr[31:8], haddr[1:0]};

  // Address phase accepted when a real transfer is selected
  assign accept = hsel && hready && (htrans == capture_pkg::htrans_nonseq);
  assign wr_en = wr_pend;

  // Address phase capture for the following write data phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= accept && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    read_value = 32'h0000_0000;
    case (haddr[7:0])
      capture_pkg::addr_control: read_value[7:0] = control;
      capture_pkg::addr_capture_low: read_value[7:0] = capture_value[7:0];
      capture_pkg::addr_capture_high: read_value[7:0] = capture_value[15:8];
      capture_pkg::addr_irq_flag: read_value[capture_pkg::flag_bit] = capture_irq_flag;
      capture_pkg::addr_irq_enable: read_value[capture_pkg::enable_bit] = capture_irq_enable;
      capture_pkg::addr_shutdown: read_value[7:0] = shutdown;
      capture_pkg::addr_timer_config: begin
        read_value[capture_pkg::timer_run_bit] = timer_run;
        read_value[capture_pkg::timer_ext_bit] = timer_ext;
      end
      capture_pkg::addr_timer_low: read_value[7:0] = timer_count[7:0];
      capture_pkg::addr_timer_high: read_value[7:0] = timer_count[15:8];
      capture_pkg::addr_pin_control: begin
        read_value[capture_pkg::pin_dir_bit] = pin_dir_input;
        read_value[capture_pkg::pin_latch_bit] = pin_latch;
      end
      capture_pkg::addr_alt_select: read_value[capture_pkg::alt_bit] = alt_select;
      default: read_value = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address phase edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      hrdata <= read_value;
    end
  end

  // Control register; a plain write changes mode without touching the prescaler
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control <= capture_pkg::control_reset;
    end else if (wr_en && wr_addr == capture_pkg::addr_control) begin
      control <= hwdata[7:0];
    end
  end

  // Shutdown control is stored and read back only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shutdown <= capture_pkg::shutdown_reset;
    end else if (wr_en && wr_addr == capture_pkg::addr_shutdown) begin
      shutdown <= hwdata[7:0];
    end
  end

  // Interrupt enable, pin control and alternate pin selection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_irq_enable <= 1'b0;
      pin_dir_input <= 1'b1;
      pin_latch <= 1'b0;
      alt_select <= 1'b0;
    end else if (wr_en) begin
      if (wr_addr == capture_pkg::addr_irq_enable) begin
        capture_irq_enable <= hwdata[capture_pkg::enable_bit];
      end
      if (wr_addr == capture_pkg::addr_pin_control) begin
        pin_dir_input <= hwdata[capture_pkg::pin_dir_bit];
        pin_latch <= hwdata[capture_pkg::pin_latch_bit];
      end
      if (wr_addr == capture_pkg::addr_alt_select) begin
        alt_select <= hwdata[capture_pkg::alt_bit];
      end
    end
  end

  // Pin driver: drives the latch when set as output
  assign capture_pin_out = pin_latch;
  assign capture_pin_oe = ~pin_dir_input;

  // Two-flop synchronisers for the pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {timer_ext_clk_in, capture_pin_alt_in, capture_pin_in};
      sync_b <= sync_a;
    end
  end

  // Detector sees the pin level whatever the direction
  assign cif.mode = control[3:0];
  assign cif.level = alt_select ? sync_b[1] : sync_b[0];

  capture_event_detector u_detector (
    .clk(clk),
    .arst_n(arst_n),
    .cif(cif)
  );

  // External clock edge, synchronised so the counter is never asynchronous
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= sync_b[2];
    end
  end
  assign ext_rise = sync_b[2] & ~ext_prev;

  // Instruction clock divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_count <= 2'h0;
    end else begin
      div_count <= div_count + 2'h1;
    end
  end
  assign instr_tick = (div_count == capture_pkg::instr_div_max);

  // Timer advance; internal clock halts in sleep, external keeps going
  assign timer_tick = timer_run && (timer_ext ? ext_rise : (instr_tick && !sleep));

  // Timer configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_run <= 1'b0;
      timer_ext <= 1'b0;
    end else if (wr_en && wr_addr == capture_pkg::addr_timer_config) begin
      timer_run <= hwdata[capture_pkg::timer_run_bit];
      timer_ext <= hwdata[capture_pkg::timer_ext_bit];
    end
  end

  // Companion 16-bit timer; software write wins over a tick
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_count <= 16'h0000;
    end else if (wr_en && wr_addr == capture_pkg::addr_timer_low) begin
      timer_count[7:0] <= hwdata[7:0];
    end else if (wr_en && wr_addr == capture_pkg::addr_timer_high) begin
      timer_count[15:8] <= hwdata[7:0];
    end else if (timer_tick) begin
      timer_count <= timer_count + 16'h0001;
    end
  end

  // Capture register, overwritten by every new event
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_value <= 16'h0000;
    end else if (cif.event_pulse) begin
      capture_value <= timer_count;
    end
  end

  // Capture flag: set wins over a write-one-to-clear
  assign flag_clear = wr_en && wr_addr == capture_pkg::addr_irq_flag && hwdata[capture_pkg::flag_bit];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_irq_flag <= 1'b0;
    end else if (cif.event_pulse) begin
      capture_irq_flag <= 1'b1;
    end else if (flag_clear) begin
      capture_irq_flag <= 1'b0;
    end
  end

  property p_capture_copy;
    @(posedge clk) disable iff (!arst_n)
      cif.event_pulse |=> capture_value == $past(timer_count);
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture value not the timer count");

  property p_overwrite;
    @(posedge clk) disable iff (!arst_n)
      (cif.event_pulse && capture_irq_flag) |=> capture_value == $past(timer_count) && capture_irq_flag;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("second capture not stored");

  property p_flag_set;
    @(posedge clk) disable iff (!arst_n)
      cif.event_pulse |=> capture_irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by capture");

  property p_flag_hold;
    @(posedge clk) disable iff (!arst_n)
      (capture_irq_flag && !flag_clear) |=> capture_irq_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without software clear");

  property p_no_event_off;
    @(posedge clk) disable iff (!arst_n)
      !capture_pkg::is_capture_mode(control[3:0]) |-> !cif.event_pulse;
  endproperty
  a_no_event_off: assert property (p_no_event_off) else $error("event outside capture mode");

  property p_sleep_hold;
    @(posedge clk) disable iff (!arst_n)
      (sleep && !timer_ext && !wr_en) |=> $stable(timer_count);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("internal timer moved in sleep");

  property p_bus_okay;
    @(posedge clk) disable iff (!arst_n)
      accept |=> hreadyout && hresp == capture_pkg::hresp_okay;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready okay");

endmodule : ccp_capture_unit

// ==== verification/capture_source.sv ====
// Far-side model: drives the capture pin level and the external timer clock.
// Assumes the bench clock and task calls from the testbench.
`timescale 1ns/1ps
module capture_source (
  input wire logic clk,    // Bench clock
  output logic pin_level,  // Level offered on the capture pin
  output logic ext_clk     // External timer clock, still between ticks
);
  // Idle levels
  initial begin
    pin_level = 1'b0;
    ext_clk = 1'b0;
  end

  // New pin level, held gap cycles, prompt or slow
  task automatic drive_pin(input logic lvl, input int gap);
    @(posedge clk);
    pin_level <= lvl;
    repeat (gap) @(posedge clk);
  endtask : drive_pin

  // One slow period, synchronised counting only
  task automatic ext_tick(input int gap);
    @(posedge clk);
    ext_clk <= 1'b1;
    repeat (gap) @(posedge clk);
    ext_clk <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask : ext_tick
endmodule : capture_source

// ==== verification/ccp_capture_unit_tb.sv ====
// Self-checking bench for the capture unit over AHB-Lite.
// Assumes zero wait states and a pin wire resolved here from the enables.
`timescale 1ns/1ps
module ccp_capture_unit_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sleep = 1'b0;
  logic alt_level = 1'b0;
  logic hreadyout, hresp, pin_out, pin_oe, src_level, src_ext;
  logic [31:0] hrdata, rd, r0;
  logic [15:0] tval;
  logic [3:0] modes [4] = '{capture_pkg::mode_fall, capture_pkg::mode_rise,
                            capture_pkg::mode_rise4, capture_pkg::mode_rise16};
  int n_mismatch = 0;
  int checked = 0;
  wire logic pin_wire = pin_oe ? pin_out : src_level;

  // Clock
  always #5 clk = ~clk;

  ccp_capture_unit dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .capture_pin_in(pin_wire), .capture_pin_alt_in(alt_level),
    .timer_ext_clk_in(src_ext), .sleep(sleep), .capture_pin_out(pin_out), .capture_pin_oe(pin_oe));

  capture_source src (.clk(clk), .pin_level(src_level), .ext_clk(src_ext));

  // Prescale count per mode
  function automatic int needed(input logic [3:0] m);
    needed = (m == capture_pkg::mode_rise16) ? 16 : (m == capture_pkg::mode_rise4) ? 4 : 1;
  endfunction : needed

  // Single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= capture_pkg::htrans_nonseq;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk("bus answer", {30'h0, hreadyout, hresp}, 32'h2);
    chk(name, rd, exp);
  endtask : rchk

  task automatic set_timer(input logic [15:0] v);
    wr(capture_pkg::addr_timer_low, {24'h0, v[7:0]});
    wr(capture_pkg::addr_timer_high, {24'h0, v[15:8]});
  endtask : set_timer

  // Off first, then the new mode, then drop any false flag
  task automatic start_mode(input logic [3:0] m);
    wr(capture_pkg::addr_control, 32'h0);
    wr(capture_pkg::addr_control, {28'h0, m});
    wr(capture_pkg::addr_irq_flag, 32'h1);
  endtask : start_mode

  task automatic rises(input int n);
    repeat (n) begin
      src.drive_pin(1'b1, 4 + $urandom_range(5));
      src.drive_pin(1'b0, 4 + $urandom_range(5));
    end
  endtask : rises

  task automatic cap_chk(input logic [15:0] v);
    rchk("flag", capture_pkg::addr_irq_flag, 32'h1);
    rchk("cap low", capture_pkg::addr_capture_low, {24'h0, v[7:0]});
    rchk("cap high", capture_pkg::addr_capture_high, {24'h0, v[15:8]});
  endtask : cap_chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    $display("Error watchdog expected end seen timeout");
    close_out();
  end

  // Main sequence
  initial begin
    void'($urandom(9067));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk("control", capture_pkg::addr_control, 32'h0);
    rchk("shutdown", capture_pkg::addr_shutdown, 32'h0);
    rchk("pin", capture_pkg::addr_pin_control, 32'h1);
    rchk("unmapped", 8'h3c, 32'h0);
    rchk("irq enable reset", capture_pkg::addr_irq_enable, 32'h0);
    wr(capture_pkg::addr_irq_enable, 32'h1);
    rchk("irq enable rw", capture_pkg::addr_irq_enable, 32'h1);
    wr(capture_pkg::addr_irq_enable, 32'h0);
    tval = 16'($urandom);
    wr(capture_pkg::addr_shutdown, {24'h0, tval[7:0]});
    rchk("shutdown rw", capture_pkg::addr_shutdown, {24'h0, tval[7:0]});
    wr(capture_pkg::addr_capture_low, 32'hff);
    rchk("capture ro", capture_pkg::addr_capture_low, 32'h0);
    $display("test registers done");
    wr(capture_pkg::addr_pin_control, 32'h1);
    wr(capture_pkg::addr_timer_config, 32'h3);
    rchk("timer config", capture_pkg::addr_timer_config, 32'h3);
    foreach (modes[i]) begin
      start_mode(modes[i]);
      tval = 16'($urandom);
      set_timer(tval);
      if (modes[i] == capture_pkg::mode_fall) begin
        src.drive_pin(1'b1, 6);
        rchk("rise in fall mode", capture_pkg::addr_irq_flag, 32'h0);
        src.drive_pin(1'b0, 6);
      end else begin
        rises(needed(modes[i]) - 1);
        rchk("flag early", capture_pkg::addr_irq_flag, 32'h0);
        rises(1);
      end
      cap_chk(tval);
    end
    $display("test modes done");
    start_mode(capture_pkg::mode_rise);
    set_timer(16'($urandom));
    rises(1);
    tval = 16'($urandom);
    set_timer(tval);
    rises(1);
    repeat (30) @(posedge clk);
    wr(capture_pkg::addr_irq_flag, 32'h0);
    cap_chk(tval);
    wr(capture_pkg::addr_irq_flag, 32'h1);
    rchk("flag cleared", capture_pkg::addr_irq_flag, 32'h0);
    $display("test overwrite done");
    start_mode(capture_pkg::mode_rise16);
    rises(3);
    wr(capture_pkg::addr_control, {28'h0, capture_pkg::mode_rise4});
    rises(1);
    rchk("count kept", capture_pkg::addr_irq_flag, 32'h1);
    start_mode(capture_pkg::mode_rise4);
    rises(3);
    start_mode(capture_pkg::mode_rise4);
    rises(1);
    rchk("count cleared", capture_pkg::addr_irq_flag, 32'h0);
    $display("test prescaler done");
    start_mode(capture_pkg::mode_rise);
    tval = 16'($urandom);
    set_timer(tval);
    wr(capture_pkg::addr_pin_control, 32'h0);
    wr(capture_pkg::addr_pin_control, 32'h2);
    repeat (8) @(posedge clk);
    chk("pin drive", {30'h0, pin_oe, pin_out}, 32'h3);
    cap_chk(tval);
    wr(capture_pkg::addr_pin_control, 32'h1);
    $display("test output pin done");
    wr(capture_pkg::addr_timer_config, 32'h1);
    sleep <= 1'b1;
    bus(1'b0, capture_pkg::addr_timer_low, 32'h0);
    r0 = rd;
    repeat (20) @(posedge clk);
    rchk("timer held", capture_pkg::addr_timer_low, r0);
    sleep <= 1'b0;
    repeat (20) @(posedge clk);
    bus(1'b0, capture_pkg::addr_timer_low, 32'h0);
    // Twenty awake cycles of a divide-by-four tick give five counts
    chk("timer resumes", {24'h0, rd[7:0] - r0[7:0]}, 32'h5);
    sleep <= 1'b1;
    wr(capture_pkg::addr_timer_config, 32'h3);
    start_mode(capture_pkg::mode_rise);
    tval = 16'($urandom);
    set_timer(tval);
    repeat (3) src.ext_tick(4 + $urandom_range(3));
    rises(1);
    cap_chk(tval + 16'h3);
    sleep <= 1'b0;
    $display("test sleep done");
    wr(capture_pkg::addr_alt_select, 32'h1);
    rchk("alt select", capture_pkg::addr_alt_select, 32'h1);
    start_mode(capture_pkg::mode_rise);
    rises(1);
    rchk("main pin unused", capture_pkg::addr_irq_flag, 32'h0);
    alt_level <= 1'b1;
    repeat (8) @(posedge clk);
    rchk("alt pin", capture_pkg::addr_irq_flag, 32'h1);
    $display("test alternate pin done");
    close_out();
  end
endmodule : ccp_capture_unit_tb
